// *** rtl/master_clock_generation.sv ***
// Master clock generator: bypass prescalers or a digital locked loop,
// then CPU and system clock enables. Registers over AHB-Lite.
// Assumes the oscillator pin is asynchronous and much slower than I_CLK.
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
module master_clock_generation
    import clock_gen_pkg::*;
(
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RSTN,
    // Oscillator pin
    input  wire logic        I_OSC_IN,
    // AHB-Lite slave
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic      [31:0] O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    // Clock enables
    output logic             O_MC_EN,
    output logic             O_MASTER_CLK,
    output logic             O_CPU_EN,
    output logic             O_EBC_EN,
    output logic             O_SYS_EN,
    output logic             O_LOCKED
);

    // ------------------------------------------------------------
    // Oscillator synchroniser
    // ------------------------------------------------------------
    logic osc_s1_q;
    logic osc_s2_q;
    logic osc_s3_q;
    logic osc_rise;

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            osc_s1_q <= I_OSC_IN;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    assign osc_rise = osc_s2_q && !osc_s3_q;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [1:0]          mode_q, mode_d;
    logic [IDIV_W-1:0]   idiv_q, idiv_d;
    logic [ODIV_W-1:0]   odiv_q, odiv_d;
    logic [MUL_W-1:0]    mul_q, mul_d;
    logic [1:0]          band_q, band_d;
    logic                halve_q, halve_d;
    logic                wr_pend_q, wr_pend_d;
    logic [7:0]          wr_addr_q, wr_addr_d;
    logic [31:0]         rdata_d;
    logic                loop_sel_q;
    logic                locked_q;
    logic [PERIOD_W-1:0] period_q;
    logic                addr_phase;
    logic [ODIV_W-1:0]   odiv_wr;

    assign addr_phase = I_HSEL && I_HTRANS[1] && I_HREADY;
    assign odiv_wr    = I_HWDATA[ODIV_LSB +: ODIV_W];

    always_comb begin
        mode_d    = mode_q;
        idiv_d    = idiv_q;
        odiv_d    = odiv_q;
        mul_d     = mul_q;
        band_d    = band_q;
        halve_d   = halve_q;
        wr_pend_d = addr_phase && I_HWRITE;
        wr_addr_d = addr_phase ? I_HADDR[7:0] : wr_addr_q;
        if (wr_pend_q && wr_addr_q == CLOCK_GEN_CONTROL_ADDR) begin
            mode_d = I_HWDATA[MODE_LSB +: 2];
            idiv_d = I_HWDATA[IDIV_LSB +: IDIV_W];
            odiv_d = (odiv_wr > ODIV_MAX) ? ODIV_MAX : odiv_wr;
            mul_d  = I_HWDATA[MUL_LSB +: MUL_W];
            band_d = I_HWDATA[BAND_LSB +: 2];
        end
        if (wr_pend_q && wr_addr_q == SYSTEM_CONTROL_ONE_ADDR) begin
            halve_d = I_HWDATA[HALVE_BIT];
        end
        // Read from next values so a read right after a write sees it
        rdata_d = 32'h0000_0000;
        if (addr_phase && !I_HWRITE) begin
            unique case (I_HADDR[7:0])
                CLOCK_GEN_CONTROL_ADDR: begin
                    rdata_d[MODE_LSB +: 2]      = mode_d;
                    rdata_d[IDIV_LSB +: IDIV_W] = idiv_d;
                    rdata_d[ODIV_LSB +: ODIV_W] = odiv_d;
                    rdata_d[MUL_LSB +: MUL_W]   = mul_d;
                    rdata_d[BAND_LSB +: 2]      = band_d;
                end
                SYSTEM_CONTROL_ONE_ADDR: rdata_d[HALVE_BIT] = halve_d;
                CLOCK_STATUS_ADDR: begin
                    rdata_d[STAT_LOCK_BIT] = locked_q;
                    rdata_d[STAT_SRC_BIT]  = loop_sel_q;
                    rdata_d[STAT_PERIOD_LSB +: PERIOD_W] = period_q;
                end
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            mode_q    <= CONTROL_RESET[MODE_LSB +: 2];
            idiv_q    <= CONTROL_RESET[IDIV_LSB +: IDIV_W];
            odiv_q    <= CONTROL_RESET[ODIV_LSB +: ODIV_W];
            mul_q     <= CONTROL_RESET[MUL_LSB +: MUL_W];
            band_q    <= CONTROL_RESET[BAND_LSB +: 2];
            halve_q   <= HALVE_RESET;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            mode_q    <= mode_d;
            idiv_q    <= idiv_d;
            odiv_q    <= odiv_d;
            mul_q     <= mul_d;
            band_q    <= band_d;
            halve_q   <= halve_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
        end
    end

    // ------------------------------------------------------------
    // Input prescaler
    // ------------------------------------------------------------
    logic ref_tick;

    tick_divider #(.W(IDIV_W)) u_input_prescaler (
        .i_clk  (I_CLK),
        .i_rstn (I_RSTN),
        .i_tick (osc_rise),
        .i_div  (idiv_q),
        .o_tick (ref_tick)
    );

    // ------------------------------------------------------------
    // Locked loop: period-steered oscillator
    // ------------------------------------------------------------
    logic                loop_req;
    logic                loop_en;
    logic [PERIOD_W-1:0] period_d;
    logic [PERIOD_W-1:0] pcnt_q, pcnt_d;
    logic [MUL_W:0]      vcnt_q, vcnt_d;
    logic                locked_d;
    logic                vco_tick;
    logic [PERIOD_W-1:0] band_min;
    logic [PERIOD_W-1:0] band_max;
    logic [MUL_W:0]      target;

    assign loop_req = (mode_q == MODE_LOOP);
    // Kept running until the output mux has left the loop source
    assign loop_en  = loop_req || loop_sel_q;
    assign target   = {1'b0, mul_q} + (MUL_W+1)'(1);

    always_comb begin
        // Reserved band code behaves as the low band
        unique case (band_q)
            BAND_MID: begin
                band_min = BAND_MID_MIN;
                band_max = BAND_MID_MAX;
            end
            BAND_HIGH: begin
                band_min = BAND_HIGH_MIN;
                band_max = BAND_HIGH_MAX;
            end
            default: begin
                band_min = BAND_LOW_MIN;
                band_max = BAND_LOW_MAX;
            end
        endcase
        vco_tick = loop_en && (pcnt_q >= period_q);
        pcnt_d   = vco_tick ? PERIOD_W'(1) : pcnt_q + PERIOD_W'(1);
        period_d = period_q;
        vcnt_d   = vcnt_q;
        locked_d = locked_q;
        if (!loop_en) begin
            pcnt_d   = '0;
            period_d = band_max;
            vcnt_d   = '0;
            locked_d = 1'b0;
        end else if (ref_tick) begin
            // One step per reference period: frequency slews, never jumps
            if (vcnt_q > target && period_q < band_max) begin
                period_d = period_q + PERIOD_W'(1);
            end else if (vcnt_q < target && period_q > band_min) begin
                period_d = period_q - PERIOD_W'(1);
            end else if (period_q > band_max) begin
                period_d = period_q - PERIOD_W'(1);
            end else if (period_q < band_min) begin
                period_d = period_q + PERIOD_W'(1);
            end
            locked_d = (vcnt_q == target);
            vcnt_d   = vco_tick ? (MUL_W+1)'(1) : '0;
        end else if (vco_tick && !(&vcnt_q)) begin
            vcnt_d = vcnt_q + (MUL_W+1)'(1);
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            period_q <= BAND_LOW_MAX;
            pcnt_q   <= '0;
            vcnt_q   <= '0;
            locked_q <= 1'b0;
        end else begin
            period_q <= period_d;
            pcnt_q   <= pcnt_d;
            vcnt_q   <= vcnt_d;
            locked_q <= locked_d;
        end
    end

    // ------------------------------------------------------------
    // Source mux and output prescaler
    // ------------------------------------------------------------
    logic loop_sel_d;
    logic src_tick;
    logic skip_q;
    logic skip_d;
    logic pre_tick;
    logic mc_tick;

    assign src_tick = loop_sel_q ? vco_tick : ref_tick;
    // New source ticks at any phase, so its first tick is dropped
    assign pre_tick = src_tick && !skip_q;

    tick_divider #(.W(ODIV_W)) u_output_prescaler (
        .i_clk  (I_CLK),
        .i_rstn (I_RSTN),
        .i_tick (pre_tick),
        .i_div  (odiv_q),
        .o_tick (mc_tick)
    );

    // Source swapped only at a master period boundary
    always_comb begin
        loop_sel_d = mc_tick ? loop_req : loop_sel_q;
        skip_d     = (loop_sel_d != loop_sel_q) || (skip_q && !src_tick);
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            loop_sel_q <= 1'b0;
            skip_q     <= 1'b0;
        end else begin
            loop_sel_q <= loop_sel_d;
            skip_q     <= skip_d;
        end
    end

    // ------------------------------------------------------------
    // CPU and system clock enables
    // ------------------------------------------------------------
    logic cpu_tick;
    logic bypass_direct;
    logic mc_en_d, master_clk_d, cpu_en_d;

    tick_divider #(.W(1)) u_cpu_divider (
        .i_clk  (I_CLK),
        .i_rstn (I_RSTN),
        .i_tick (mc_tick),
        .i_div  (halve_q),
        .o_tick (cpu_tick)
    );

    assign bypass_direct = !loop_sel_q && idiv_q == '0 && odiv_q == '0;

    always_comb begin
        mc_en_d      = mc_tick;
        // Undivided bypass copies the pin level, keeping its duty cycle
        master_clk_d = bypass_direct ? osc_s3_q : mc_tick;
        cpu_en_d     = cpu_tick;
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            O_MC_EN      <= 1'b0;
            O_MASTER_CLK <= 1'b0;
            O_CPU_EN     <= 1'b0;
            O_EBC_EN     <= 1'b0;
            O_SYS_EN     <= 1'b0;
            O_LOCKED     <= 1'b0;
            O_HRDATA     <= 32'h0000_0000;
            O_HREADYOUT  <= 1'b1;
            O_HRESP      <= 1'b0;
        end else begin
            O_MC_EN      <= mc_en_d;
            O_MASTER_CLK <= master_clk_d;
            O_CPU_EN     <= cpu_en_d;
            O_EBC_EN     <= cpu_en_d;
            O_SYS_EN     <= cpu_en_d;
            O_LOCKED     <= locked_q;
            O_HRDATA     <= rdata_d;
            O_HREADYOUT  <= 1'b1;
            O_HRESP      <= 1'b0;
        end
    end

endmodule : master_clock_generation

// *** rtl/clock_gen_pkg.sv ***
// Constants, register map and field layout of the master clock generator.
// Assumes a 32-bit AHB-Lite register port and one 200 MHz system clock.
//
// Function
// - Two-bit mode picks bypass or loop source
// - Bypass divides by (input+1)*(output+1)
// - Both dividers zero: master follows oscillator
// - Input divider to 3, output divider to 14
// - Loop mode enables loop, multiplies by multiplier+1
// - Loop output passes through output prescaler
// - Loop frequency slews gradually, never steps
// - Band field picks VCO range, 11 reserved
// - CPU clock is master or master halved
// - Core and bus controller use CPU clock
// - System clock rate equals CPU clock rate
package clock_gen_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CLOCK_GEN_CONTROL_ADDR  = 8'h00;
    localparam logic [7:0] SYSTEM_CONTROL_ONE_ADDR = 8'h04;
    localparam logic [7:0] CLOCK_STATUS_ADDR       = 8'h08;

    // ------------------------------------------------------------
    // Field layout and limits
    // ------------------------------------------------------------
    localparam int MODE_LSB  = 0;
    localparam int IDIV_LSB  = 2;
    localparam int ODIV_LSB  = 4;
    localparam int MUL_LSB   = 8;
    localparam int BAND_LSB  = 13;
    localparam int IDIV_W    = 2;
    localparam int ODIV_W    = 4;
    localparam int MUL_W     = 5;
    localparam int PERIOD_W  = 12;
    localparam int STAT_PERIOD_LSB = 8;
    localparam int HALVE_BIT       = 0;
    localparam int STAT_LOCK_BIT   = 0;
    localparam int STAT_SRC_BIT    = 1;
    localparam logic [ODIV_W-1:0] ODIV_MAX = 4'hE;

    // ------------------------------------------------------------
    // Modes and bands
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_LOOP  = 2'h3;
    localparam logic [1:0] BAND_LOW   = 2'h0;
    localparam logic [1:0] BAND_MID   = 2'h1;
    localparam logic [1:0] BAND_HIGH  = 2'h2;

    // VCO period limits in system clock cycles, scaled model
    localparam logic [PERIOD_W-1:0] BAND_LOW_MIN  = 12'h018;
    localparam logic [PERIOD_W-1:0] BAND_LOW_MAX  = 12'h028;
    localparam logic [PERIOD_W-1:0] BAND_MID_MIN  = 12'h010;
    localparam logic [PERIOD_W-1:0] BAND_MID_MAX  = 12'h018;
    localparam logic [PERIOD_W-1:0] BAND_HIGH_MIN = 12'h008;
    localparam logic [PERIOD_W-1:0] BAND_HIGH_MAX = 12'h010;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic        HALVE_RESET   = 1'b0;

endpackage : clock_gen_pkg

// *** rtl/tick_divider.sv ***
// Divides a stream of one-cycle tick pulses by (divisor + 1).
// Assumes input ticks are single-cycle pulses on the same clock.
`timescale 1ns/100ps
module tick_divider #(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    // Tick stream
    input  wire logic         i_tick,
    input  wire logic [W-1:0] i_div,
    output logic              o_tick
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic [W-1:0] div_q;
    logic [W-1:0] div_d;
    logic         wrap;

    // A zero-width divisor cannot count
    if (W < 1) begin : g_bad_width
        $error("tick_divider needs W of at least 1");
    end

    // New divisor only taken at a period boundary, so no pulse is cut
    always_comb begin
        wrap  = i_tick && (cnt_q == div_q);
        cnt_d = cnt_q;
        div_d = div_q;
        if (wrap) begin
            cnt_d = '0;
            div_d = i_div;
        end else if (i_tick) begin
            cnt_d = cnt_q + W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cnt_q <= '0;
            div_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            div_q <= div_d;
        end
    end

    assign o_tick = wrap;

endmodule : tick_divider

// *** bench/clock_gen_asserts.sv ***
// Checker: clock enable and bus answer relations.
// Assumes binding onto master_clock_generation ports.
`timescale 1ns/100ps
module clock_gen_asserts (
    // Clock and reset
    input wire logic        I_CLK,
    input wire logic        I_RSTN,
    // Bus
    input wire logic        I_HSEL,
    input wire logic [1:0]  I_HTRANS,
    input wire logic        I_HWRITE,
    input wire logic        I_HREADY,
    input wire logic [31:0] O_HRDATA,
    input wire logic        O_HREADYOUT,
    input wire logic        O_HRESP,
    // Enables
    input wire logic        O_MC_EN,
    input wire logic        O_CPU_EN,
    input wire logic        O_EBC_EN,
    input wire logic        O_SYS_EN,
    input wire logic        O_LOCKED
);
    // ----------------
    // Helpers
    // ----------------
    logic rd_q, rd_d;
    logic mc_q, mc_d;
    always_comb begin
        rd_d = I_HSEL && I_HTRANS[1] && I_HREADY && !I_HWRITE;
        mc_d = O_CPU_EN ? 1'b0 : (O_MC_EN ? 1'b1 : mc_q);
    end
    always_ff @(posedge I_CLK) begin
        rd_q <= I_RSTN ? rd_d : 1'b0;
        mc_q <= I_RSTN ? mc_d : 1'b0;
    end
    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    AST_EBC_CPU: assert property (O_EBC_EN == O_CPU_EN) else $error("bus ctrl enable differs");
    AST_SYS_CPU: assert property (O_SYS_EN == O_CPU_EN) else $error("system enable differs");
    AST_CPU_ON_MC: assert property (O_CPU_EN |-> O_MC_EN) else $error("cpu pulse off master");
    AST_CPU_SECOND: assert property (O_MC_EN && mc_q |-> O_CPU_EN) else $error("cpu pulse skipped");
    AST_MC_GAP: assert property (O_MC_EN |=> !O_MC_EN [*7]) else $error("master pulse cut short");
    AST_RST_QUIET: assert property ($rose(I_RSTN) |-> !O_MC_EN && !O_CPU_EN && !O_LOCKED) else $error("pulse at reset");
    AST_RD_IDLE: assert property (!rd_q |-> O_HRDATA == 32'h0) else $error("read data outside phase");
    AST_BUS_OK: assert property (O_HREADYOUT && !O_HRESP) else $error("bus not ready or error");
    // Halving only seen as a master pulse with no CPU pulse, the first of each pair
    COV_HALVE: cover property (O_MC_EN && !O_CPU_EN);
    COV_LOCK: cover property ($rose(O_LOCKED));
    COV_READ: cover property (rd_q);
endmodule : clock_gen_asserts

bind master_clock_generation clock_gen_asserts u_asserts (
    .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_HSEL(I_HSEL), .I_HTRANS(I_HTRANS),
    .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
    .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_MC_EN(O_MC_EN),
    .O_CPU_EN(O_CPU_EN), .O_EBC_EN(O_EBC_EN), .O_SYS_EN(O_SYS_EN), .O_LOCKED(O_LOCKED)
);

// *** bench/osc_source.sv ***
// Oscillator pin model, free running with set high and low times.
// Assumes times change only between measurements.
`timescale 1ns/100ps
module osc_source (
    // Timing in ns
    input  wire logic [15:0] i_high_ns,
    input  wire logic [15:0] i_low_ns,
    // Pin
    output logic             o_osc
);
    // Offset keeps pin edges clear of clock edges
    initial begin
        o_osc = 1'b0;
        #1.3;
        forever begin
            #(i_low_ns);
            o_osc = 1'b1;
            #(i_high_ns);
            o_osc = 1'b0;
        end
    end
endmodule : osc_source

// *** bench/master_clock_generation_test.sv ***
// Bench: register reads, bypass divide, halving and loop bands.
// Assumes osc_source drives the pin and the checker is bound in.
`timescale 1ns/100ps
module master_clock_generation_test
    import clock_gen_pkg::*;
;
    logic        clk, rstn, osc, hsel, hwrite, rdy, rd_dp, mc_en, mclk, cpu_en, locked;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [15:0] t_hi, t_lo;
    logic [31:0] exp_q[$], msk_q[$];
    int          mismatches, n_compared, n, i, o, e, b;
    int          tab_i[5] = '{0, 1, 0, 3, 2};
    int          tab_o[5] = '{0, 0, 1, 14, 15};

    osc_source u_osc (.i_high_ns(t_hi), .i_low_ns(t_lo), .o_osc(osc));
    master_clock_generation u_dut (
        .I_CLK(clk), .I_RSTN(rstn), .I_OSC_IN(osc), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
        .I_HREADY(rdy), .O_HRDATA(hrdata), .O_HREADYOUT(rdy), .O_HRESP(),
        .O_MC_EN(mc_en), .O_MASTER_CLK(mclk), .O_CPU_EN(cpu_en), .O_EBC_EN(),
        .O_SYS_EN(), .O_LOCKED(locked)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ----------------
    // Tasks
    // ----------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    // Called right after an edge, so transfers run back to back
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        do @(posedge clk); while (rdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (rdy !== 1'b1);
    endtask : ahb
    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk);
        exp_q.push_back(ex);
        msk_q.push_back(mk);
        ahb(1'b0, a, 32'h0);
    endtask : rd
    // Last of three gaps, so a pending divider reload has settled
    task automatic meas(input logic cpu);
        do @(posedge clk); while ((cpu ? cpu_en : mc_en) !== 1'b1);
        repeat (3) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while ((cpu ? cpu_en : mc_en) !== 1'b1);
        end
    endtask : meas
    // ----------------
    // Read data monitor
    // ----------------
    always @(posedge clk) begin
        if (rd_dp && rdy === 1'b1 && exp_q.size() > 0) begin
            chk(hrdata & msk_q[0], exp_q[0] & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        rd_dp <= hsel && htrans[1] && rdy && !hwrite;
    end
    initial begin
        #400000;
        mismatches++;
        end_sim();
    end
    // ----------------
    // Scenarios
    // ----------------
    initial begin
        mismatches = 0;
        n_compared = 0;
        rstn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        t_hi = 16'd15;
        t_lo = 16'd35;
        n = $urandom(32'h2933);
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(CLOCK_GEN_CONTROL_ADDR, CONTROL_RESET, 32'hFFFF_FFFF);
        rd(SYSTEM_CONTROL_ONE_ADDR, 32'h0, 32'hFFFF_FFFF);
        rd(CLOCK_STATUS_ADDR, 32'h0, 32'h3);
        ahb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        rd(8'h0C, 32'h0, 32'hFFFF_FFFF);
        do @(posedge clk); while (mclk !== 1'b0);
        do @(posedge clk); while (mclk !== 1'b1);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (mclk === 1'b1);
        chk(n, 32'd3);
        for (int k = 0; k < 7; k++) begin
            i = (k < 5) ? tab_i[k] : $urandom % 4;
            o = (k < 5) ? tab_o[k] : $urandom % 16;
            e = (o > 14) ? 14 : o;
            ahb(1'b1, CLOCK_GEN_CONTROL_ADDR, {24'h0, 4'(o), 2'(i), 2'(k % 3)});
            rd(CLOCK_GEN_CONTROL_ADDR, {24'h0, 4'(e), 2'(i), 2'(k % 3)}, 32'hFFFF_FFFF);
            meas(1'b0);
            chk(n, 10 * (i + 1) * (e + 1));
        end
        ahb(1'b1, CLOCK_GEN_CONTROL_ADDR, 32'h10);
        ahb(1'b1, SYSTEM_CONTROL_ONE_ADDR, 32'h1);
        meas(1'b1);
        chk(n, 32'd40);
        ahb(1'b1, SYSTEM_CONTROL_ONE_ADDR, 32'h0);
        meas(1'b1);
        chk(n, 32'd20);
        t_hi <= 16'd500;
        t_lo <= 16'd500;
        // Target period 20 cycles: only band 01 can reach it
        for (b = 0; b < 4; b++) begin
            ahb(1'b1, CLOCK_GEN_CONTROL_ADDR, 32'h0);
            repeat (600) @(posedge clk);
            ahb(1'b1, CLOCK_GEN_CONTROL_ADDR, {17'h0, 2'(b), 5'd9, 4'd1, 2'd0, 2'h3});
            repeat (8000) @(posedge clk);
            rd(CLOCK_STATUS_ADDR, (b == 1) ? 32'h1403 : ((b == 2) ? 32'h1002 : 32'h1802), 32'hF_FF03);
            chk(locked, (b == 1) ? 32'h1 : 32'h0);
            if (b == 1) begin
                meas(1'b0);
                chk(n, 32'd40);
            end
        end
        end_sim();
    end
endmodule : master_clock_generation_test
